// ==== rtl/wit_pkg.sv ====
// package for the watch/interval timer: register map, field layout, timing
// assumes a single 40 MHz clock domain and the plain register port
package wit_pkg;
    // register addresses (byte addresses on the register port)
    localparam logic [31:0] baud_compare_value_addr    = 32'hfffff8b1;
    localparam logic [31:0] clock_supply_ctrl_addr     = 32'hfffff8b0;
    localparam logic [31:0] watch_operation_ctrl_addr  = 32'hfffff8b2;
    localparam logic [31:0] irq_status_addr            = 32'hfffff8b3;
    localparam logic [31:0] irq_enable_addr            = 32'hfffff8b4;
    localparam logic [31:0] irq_clear_addr             = 32'hfffff8b5;

    // reset values
    localparam logic [7:0] compare_reset  = 8'h00;
    localparam logic [7:0] ctrl_reset     = 8'h00;

    // clock_supply_ctrl_unit0 fields
    localparam int supply_src_lsb   = 0;   // [1:0] source: main clock, /2, /4, /8
    localparam int supply_bgce_bit  = 4;   // baud_counter_clock_enable
    // watch_operation_ctrl fields
    localparam int wt_run_bit       = 0;   // watch counter run
    localparam int wt_pre_run_bit   = 1;   // prescaler / interval run
    localparam int wt_cnt_sel_bit   = 2;   // 5-bit counter clock: wclk or wclk/2^9
    localparam int wt_clk_sel_bit   = 3;   // watch clock: main path or subclock
    localparam int wt_int_lsb       = 4;   // [5:4] watch interval select
    localparam int wt_ivl_lsb       = 6;   // [7:6] interval tap select
    localparam int ivl_sel_width    = 3;   // interval tap select width

    // prescaler tap positions (bit k toggles at wclk/2^(k+1))
    localparam int tap_first        = 3;   // wclk/2^4
    localparam int tap_div9         = 8;   // wclk/2^9
    localparam int presc_width      = 11;

    // status bits
    localparam int irq_watch_bit    = 0;
    localparam int irq_interval_bit = 1;
    localparam int irq_baud_bit     = 2;
    localparam int irq_width        = 3;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } wit_bus_req_type;

    typedef enum logic [1:0] {
        wit_int_2e4,
        wit_int_2e13,
        wit_int_2e5,
        wit_int_2e14
    } wit_int_sel_type;
endpackage

// ==== rtl/wit_baud_gen.sv ====
// baud-rate generator: 8-bit compare counter, toggled output
// assumes a one-cycle count enable at the selected source rate
`timescale 1ns/1ps
module wit_baud_gen #(
    parameter int width = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic [width-1:0] compare,
    output logic                  baud_clk_q,
    output logic                  match
);
    logic [width-1:0] cnt_q;

    // stored zero means N = full range, matched at all-ones
    assign match = run && tick && (cnt_q == (compare - width'(1)));

    // count source ticks, clear and toggle on match
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt_q      <= '0;
            baud_clk_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!run)
            begin
                cnt_q      <= '0;
                baud_clk_q <= 1'b0;
            end
            else if (match)
            begin
                cnt_q      <= '0;
                baud_clk_q <= ~baud_clk_q;
            end
            else if (tick)
                cnt_q <= cnt_q + width'(1);
        end
    end
endmodule

// ==== rtl/wit_top.sv ====
// watch timer / interval timer with front-end prescaler and baud generator
// assumes subclock pin asynchronous to clock, registers on the plain port
// Function
// - gate main clock supply to watch timer
// - 3-bit prescaler picks main clock, /2, /4, /8
// - 8-bit counter counts the source clock
// - baud rate is source over 2N, 0 means 256
// - select main path or subclock as watch clock
// - 11-bit prescaler gives wclk/2^4 to /2^11
// - 5-bit counter counts wclk or wclk/2^9
// - watch interrupt at 2^4, 2^5, 2^13, 2^14
// - interval interrupt from prescaler taps 2^4..2^7
// - compare register 8 bits, RW, resets zero
// - clock supply register governs watch clock feed
// - operation register starts timers, picks interval
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module wit_top #(
    parameter int cnt_width = 5
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [31:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        subclock,
    output logic             baud_rate_clock,
    output logic             watch_irq,
    output logic             interval_irq,
    output logic             irq
);
    wit_pkg::wit_bus_req_type req;
    logic [7:0]  compare_q;
    logic [7:0]  supply_q;
    logic [7:0]  op_ctrl_q;
    logic [wit_pkg::irq_width-1:0] status_q;
    logic [wit_pkg::irq_width-1:0] enable_q;
    logic [2:0]  pre3_q;
    logic        src_tick;
    logic        baud_match;
    logic        baud_clk;
    logic [2:0]  sub_sync_q;
    logic        sub_rise;
    logic        main_tick;
    logic        wclk_tick;
    logic [wit_pkg::presc_width-1:0] presc_q;
    logic [wit_pkg::presc_width-1:0] presc_d;
    logic [wit_pkg::presc_width-1:0] presc_rise;
    logic [cnt_width-1:0] cnt5_q;
    logic        cnt_tick;
    logic        watch_ev;
    logic        interval_ev;
    logic [2:0]  ivl_sel;
    logic [wit_pkg::irq_width-1:0] events;

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // software registers; compare clears at reset
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            compare_q <= wit_pkg::compare_reset;
            supply_q  <= wit_pkg::ctrl_reset;
            op_ctrl_q <= wit_pkg::ctrl_reset;
            enable_q  <= '0;
        end
        else if (ce && req.wr)
        begin
            case (req.addr)
                wit_pkg::baud_compare_value_addr:   compare_q <= req.wdata;
                wit_pkg::clock_supply_ctrl_addr:    supply_q  <= req.wdata;
                wit_pkg::watch_operation_ctrl_addr: op_ctrl_q <= req.wdata;
                wit_pkg::irq_enable_addr:
                    enable_q <= req.wdata[wit_pkg::irq_width-1:0];
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (ce)
        begin
            rdata <= 8'h00;
            if (req.rd)
            begin
                case (req.addr)
                    wit_pkg::baud_compare_value_addr:   rdata <= compare_q;
                    wit_pkg::clock_supply_ctrl_addr:    rdata <= supply_q;
                    wit_pkg::watch_operation_ctrl_addr: rdata <= op_ctrl_q;
                    wit_pkg::irq_status_addr:   rdata <= {5'h00, status_q};
                    wit_pkg::irq_enable_addr:   rdata <= {5'h00, enable_q};
                    default:                    rdata <= 8'h00;
                endcase
            end
        end
    end

    // 3-bit prescaler runs only while the baud counter clock is supplied
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pre3_q <= 3'h0;
        else if (ce)
        begin
            if (supply_q[wit_pkg::supply_bgce_bit])
                pre3_q <= pre3_q + 3'h1;
            else
                pre3_q <= 3'h0;
        end
    end

    // source tick: every cycle, or wrap of the low 1, 2, 3 prescaler bits
    always_comb
    begin
        case (supply_q[wit_pkg::supply_src_lsb +: 2])
            2'h0:    src_tick = 1'b1;
            2'h1:    src_tick = pre3_q[0];
            2'h2:    src_tick = &pre3_q[1:0];
            2'h3:    src_tick = &pre3_q;
            default: src_tick = 1'b0;
        endcase
    end

    wit_baud_gen #(
        .width (8)
    ) u_baud (
        .clock      (clock),
        .rst        (rst),
        .ce         (ce),
        .run        (supply_q[wit_pkg::supply_bgce_bit]),
        .tick       (src_tick),
        .compare    (compare_q),
        .baud_clk_q (baud_clk),
        .match      (baud_match)
    );

    // output reflects the toggled register directly
    assign baud_rate_clock = baud_clk;

    // subclock synchroniser; edge taken only from the second stage on
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sub_sync_q <= 3'h0;
        else if (ce)
            sub_sync_q <= {sub_sync_q[1:0], subclock};
    end
    assign sub_rise = sub_sync_q[1] & ~sub_sync_q[2];

    // main path: each half-period of the baud clock is one watch clock edge
    assign main_tick = baud_match;
    assign wclk_tick = op_ctrl_q[wit_pkg::wt_clk_sel_bit] ? sub_rise : main_tick;

    // 11-bit prescaler, held clear while stopped
    assign presc_d = presc_q + wit_pkg::presc_width'(1);
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            presc_q <= '0;
        else if (ce)
        begin
            if (!op_ctrl_q[wit_pkg::wt_pre_run_bit])
                presc_q <= '0;
            else if (wclk_tick)
                presc_q <= presc_d;
        end
    end

    // a tap fires when its bit falls, i.e. every 2^(k+1) watch clock edges
    genvar k;
    generate
        for (k = 0; k < wit_pkg::presc_width; k++)
        begin : g_tap
            assign presc_rise[k] = wclk_tick && (&presc_q[k:0]);
        end
    endgenerate

    // interval select: tap wclk/2^(4+sel); field is only two bits wide
    assign ivl_sel = {1'b0, op_ctrl_q[wit_pkg::wt_ivl_lsb +: 2]};
    assign interval_ev = op_ctrl_q[wit_pkg::wt_pre_run_bit]
                       && presc_rise[wit_pkg::tap_first + int'(ivl_sel)];

    // 5-bit counter clock: wclk or wclk/2^9 (the latter needs the prescaler running)
    assign cnt_tick = op_ctrl_q[wit_pkg::wt_cnt_sel_bit]
                    ? presc_rise[wit_pkg::tap_div9] : wclk_tick;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt5_q <= '0;
        else if (ce)
        begin
            if (!op_ctrl_q[wit_pkg::wt_run_bit])
                cnt5_q <= '0;
            else if (cnt_tick)
                cnt5_q <= cnt5_q + cnt_width'(1);
        end
    end

    // watch interval: 2^4 or 2^5 counts of wclk; 2^13 or 2^14 with wclk/2^9
    always_comb
    begin
        case (wit_pkg::wit_int_sel_type'(op_ctrl_q[wit_pkg::wt_int_lsb +: 2]))
            wit_pkg::wit_int_2e4:  watch_ev = cnt_tick && (&cnt5_q[3:0]);
            wit_pkg::wit_int_2e5:  watch_ev = cnt_tick && (&cnt5_q[4:0]);
            wit_pkg::wit_int_2e13: watch_ev = cnt_tick && (&cnt5_q[3:0]);
            wit_pkg::wit_int_2e14: watch_ev = cnt_tick && (&cnt5_q[4:0]);
            default:               watch_ev = 1'b0;
        endcase
    end

    // one-cycle interrupt request pulses
    assign watch_irq    = ce && op_ctrl_q[wit_pkg::wt_run_bit] && watch_ev;
    assign interval_irq = ce && interval_ev;

    assign events[wit_pkg::irq_watch_bit]    = watch_irq;
    assign events[wit_pkg::irq_interval_bit] = interval_irq;
    assign events[wit_pkg::irq_baud_bit]     = ce && baud_match;

    // sticky status; a new event beats a simultaneous clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            status_q <= '0;
        else if (ce)
        begin
            if (req.wr && req.addr == wit_pkg::irq_clear_addr)
                status_q <= (status_q & ~req.wdata[wit_pkg::irq_width-1:0]) | events;
            else
                status_q <= status_q | events;
        end
    end

    // level interrupt while any enabled bit stands
    assign irq = |(status_q & enable_q);
endmodule

// ==== test/wit_top_sva.sv ====
// port checker for the watch/interval timer
// assumes one clock domain and the plain register port
`timescale 1ns/1ps
module wit_top_sva #(
    parameter int cnt_width = 5
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic [31:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        subclock,
    input wire logic        baud_rate_clock,
    input wire logic        watch_irq,
    input wire logic        interval_irq,
    input wire logic        irq
);
    // single domain, so one clocking and one disable
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (!$past(rd) && $past(ce) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_compare_readback: assert property (wr && ce && addr == wit_pkg::baud_compare_value_addr
        ##2 rd && ce && addr == wit_pkg::baud_compare_value_addr
        |=> rdata == $past(wdata, 3))
        else $error("compare value not read back");
    a_unmapped_zero: assert property (rd && ce && addr[31:8] != 24'hfffff8 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(wr) || $past(watch_irq)
        || $past(interval_irq) || $changed(baud_rate_clock)
        || $past(baud_rate_clock, 2) != $past(baud_rate_clock))
        else $error("irq rose without an event");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without a write");
    a_watch_pulse: assert property (watch_irq ##1 ce |-> !watch_irq)
        else $error("watch pulse longer than one cycle");
    a_interval_pulse: assert property ($rose(interval_irq) ##1 ce |-> $fell(interval_irq))
        else $error("interval pulse longer than one cycle");
    a_freeze_ce: assert property (!ce |=> $stable(baud_rate_clock) && $stable(irq))
        else $error("state moved while clock gated");
endmodule
bind wit_top wit_top_sva #(.cnt_width(cnt_width)) u_sva (.clock(clock), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .subclock(subclock),
    .baud_rate_clock(baud_rate_clock), .watch_irq(watch_irq), .interval_irq(interval_irq),
    .irq(irq));

// ==== test/watch_interval_timer_tb_top.sv ====
// self-checking bench for the watch/interval timer
// assumes the 40 MHz clock and the plain register port of wit_top
`timescale 1ns/1ps
module watch_interval_timer_tb_top;
    logic        clock, rst, ce, wr, rd, subclock;
    logic [31:0] addr;
    logic [7:0]  wdata, rdata;
    logic        baud_rate_clock, watch_irq, interval_irq, irq;
    int          fails, n_compared, cycles;
    int          wexp [4] = '{16, 8192, 32, 16384};
    wit_top #(.cnt_width(5)) u_dut (.clock(clock), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .subclock(subclock),
        .baud_rate_clock(baud_rate_clock), .watch_irq(watch_irq),
        .interval_irq(interval_irq), .irq(irq));
    // 25 ns clock; subclock at an eighth of it, free running
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial
    begin
        subclock = 1'b0;
        forever
        begin
            repeat (4) @(posedge clock);
            subclock <= ~subclock;
        end
    end
    // hang guard, above the longest watch period pair
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 99000)
        begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_n(input string what, input int e, input int g);
        n_compared++;
        if (g != e)
        begin
            fails++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // bus tasks start and end just after a rising edge
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        // one idle edge, so a following write never reassigns the strobe
        @(posedge clock);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [7:0] m, input logic [7:0] e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        @(negedge clock);
        check8("read", e, rdata & m);
        @(posedge clock);
    endtask
    task automatic irq_chk(input logic e);
        @(negedge clock);
        check8("irq", {7'h00, e}, {7'h00, irq});
        @(posedge clock);
    endtask
    // spacing between two events: 0 baud edge, 1 watch, 2 interval
    task automatic gap(input int w, input int e);
        int   n, k;
        logic last;
        n = 0;
        k = 0;
        last = baud_rate_clock;
        while (k < 2 && n < 40000)
        begin
            @(negedge clock);
            n++;
            if (w == 0 ? baud_rate_clock !== last : w == 1 ? watch_irq === 1'b1
                : interval_irq === 1'b1)
            begin
                if (k == 0)
                    n = 0;
                k++;
            end
            last = baud_rate_clock;
        end
        check_n("period", e, n);
        @(posedge clock);
    endtask
    task automatic t_regs();
        rd_chk(wit_pkg::baud_compare_value_addr, 8'hff, 8'h00);
        rd_chk(wit_pkg::irq_enable_addr, 8'hff, 8'h00);
        wr_reg(wit_pkg::baud_compare_value_addr, 8'ha5);
        rd_chk(wit_pkg::baud_compare_value_addr, 8'hff, 8'ha5);
        rd_chk(32'h00000010, 8'hff, 8'h00);
    endtask
    // compare written before the counter clock is enabled
    task automatic t_baud();
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(wit_pkg::baud_compare_value_addr, 8'h03);
            wr_reg(wit_pkg::clock_supply_ctrl_addr, 8'h10 | 8'(s));
            gap(0, 3 << s);
            wr_reg(wit_pkg::clock_supply_ctrl_addr, 8'h00);
        end
        wr_reg(wit_pkg::baud_compare_value_addr, 8'h00);
        wr_reg(wit_pkg::clock_supply_ctrl_addr, 8'h10);
        gap(0, 256);
        ce <= 1'b0;
        repeat (6) @(posedge clock);
        ce <= 1'b1;
    endtask
    // main path with N=1 gives one watch clock per cycle
    task automatic t_timers();
        wr_reg(wit_pkg::clock_supply_ctrl_addr, 8'h00);
        wr_reg(wit_pkg::baud_compare_value_addr, 8'h01);
        wr_reg(wit_pkg::clock_supply_ctrl_addr, 8'h10);
        for (int c = 0; c < 4; c++)
        begin
            // odd codes count wclk/2^9, so the prescaler must run as well
            wr_reg(wit_pkg::watch_operation_ctrl_addr,
                   8'h01 | 8'(c << 4) | (c[0] ? 8'h06 : 8'h00));
            gap(1, wexp[c]);
        end
        for (int s = 0; s < 4; s++)
        begin
            wr_reg(wit_pkg::watch_operation_ctrl_addr, 8'h02 | 8'(s << 6));
            gap(2, 16 << s);
        end
        wr_reg(wit_pkg::watch_operation_ctrl_addr, 8'h0a);
        gap(2, 128);
    endtask
    task automatic t_irq();
        wr_reg(wit_pkg::watch_operation_ctrl_addr, 8'h01);
        wr_reg(wit_pkg::irq_enable_addr, 8'h01);
        gap(1, 16);
        irq_chk(1'b1);
        rd_chk(wit_pkg::irq_status_addr, 8'h01, 8'h01);
        wr_reg(wit_pkg::irq_enable_addr, 8'h00);
        irq_chk(1'b0);
        wr_reg(wit_pkg::watch_operation_ctrl_addr, 8'h00);
        wr_reg(wit_pkg::irq_enable_addr, 8'h01);
        wr_reg(wit_pkg::irq_clear_addr, 8'h07);
        irq_chk(1'b0);
        rd_chk(wit_pkg::irq_status_addr, 8'h01, 8'h00);
        // baud matches every cycle here, so its bit survives the clear
        rd_chk(wit_pkg::irq_status_addr, 8'h04, 8'h04);
    endtask
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h00000000;
        wdata = 8'h00;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_baud();
        t_timers();
        t_irq();
        print_verdict();
    end
endmodule
